//--- logic/loss_mode_pkg.sv
// loss_mode_pkg: constants and mode codes for the frame loss mode selector
// assumes energy figures arrive as unsigned Q0.16 fractions
package loss_mode_pkg;

  // widths
  localparam int ENERGY_W = 16;
  localparam int RUN_W = 8;
  localparam int HZ_W = 16;
  localparam int HIST_W = 3;

  // energy thresholds as printed, and their Q0.16 compare values
  localparam real ED_THRESH = 0.159063;
  localparam real STAT_THRESH = 0.032209;
  // x < t*65536 for integer x is x < ceil(t*65536)
  localparam logic [ENERGY_W-1:0] ED_THRESH_Q16 = 16'h28B9;
  localparam logic [ENERGY_W-1:0] STAT_THRESH_Q16 = 16'h083F;
  // small energy change limit for phase alignment eligibility
  localparam logic [ENERGY_W-1:0] SMALL_CHANGE_Q16 = 16'h083F;

  // peak sub-band window for phase alignment, in Hz
  localparam logic [HZ_W-1:0] PEAK_LO_HZ = 16'h004B;
  localparam logic [HZ_W-1:0] PEAK_HI_HZ = 16'h03E8;

  // run count figures
  localparam logic [RUN_W-1:0] RUN_ONE = 8'h01;

  // values after reset
  localparam logic RST_FLAG = 1'b0;
  localparam logic [HIST_W-1:0] RST_HIST = 3'h0;

  // selected concealment mode, one-hot
  typedef enum logic [6:0] {
    MODE_OVERLAP_ADD = 7'h01,
    MODE_PA_ERASED = 7'h02,
    MODE_PA_NEXT_GOOD = 7'h04,
    MODE_PA_BURST = 7'h08,
    MODE_RS_ERASED = 7'h10,
    MODE_RS_NEXT_GOOD = 7'h20,
    MODE_NEXT_GOOD_AFTER_BURST = 7'h40
  } conceal_mode_e;

endpackage

//--- logic/stationarity_if.sv
// stationarity_if: carries energy and stationarity between selector and tracker
// assumes one clock domain shared by both ends
`timescale 1ns/100ps
`default_nettype none
interface stationarity_if;
  logic update;
  logic [loss_mode_pkg::ENERGY_W-1:0] energy_delta;
  logic stationary_now;
  logic stationary_final;

  modport tracker (input update, input energy_delta, output stationary_now, output stationary_final);
  modport selector (output update, output energy_delta, input stationary_now, input stationary_final);
endinterface
`default_nettype wire

//--- logic/stationarity_tracker.sv
// stationarity_tracker: per-frame stationarity with hysteresis
// assumes update is a one-cycle pulse once per frame, clock enable gates the registers here
`timescale 1ns/100ps
`default_nettype none
module stationarity_tracker (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // frame side
  stationarity_if.tracker st
);

  logic stationary_prev;
  logic stationary_final;
  logic next_stationary_prev;
  logic next_stationary_final;

  ////////////////////////////////////////////////////////////////////////
  // current stationarity from energy difference
  assign st.stationary_now = (st.energy_delta < loss_mode_pkg::STAT_THRESH_Q16);
  assign st.stationary_final = stationary_final;

  // hysteresis: final follows only when two frames agree
  always_comb begin
    next_stationary_prev = stationary_prev;
    next_stationary_final = stationary_final;
    if (st.update) begin
      if (st.stationary_now == stationary_prev) begin
        next_stationary_final = st.stationary_now;
      end
      next_stationary_prev = st.stationary_now;
    end
  end

  // state registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stationary_prev <= loss_mode_pkg::RST_FLAG;
      stationary_final <= loss_mode_pkg::RST_FLAG;
    end else if (clk_en) begin
      stationary_prev <= next_stationary_prev;
      stationary_final <= next_stationary_final;
    end
  end

endmodule
`default_nettype wire

//--- logic/frame_loss_mode_select.sv
// frame_loss_mode_select: once-per-frame choice of concealment mode
// assumes frame decoder inputs are stable and valid in the cycle of frame_strobe
// assumes clk_en low freezes every register, the strobe echo included
`timescale 1ns/100ps
`default_nettype none
module frame_loss_mode_select (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // frame decoder inputs
  input wire logic frame_strobe,
  input wire logic bad_frame,
  input wire logic prev_freq_domain,
  input wire logic [loss_mode_pkg::RUN_W-1:0] lost_frame_run_count,
  input wire logic [loss_mode_pkg::ENERGY_W-1:0] energy_delta,
  // good-frame analysis for phase alignment eligibility
  input wire logic [loss_mode_pkg::HZ_W-1:0] peak_band_hz,
  input wire logic band_index_steady,
  input wire logic frame_transient,
  // decision outputs to concealment datapath
  output logic [6:0] conceal_mode,
  output logic mode_valid,
  output logic freq_domain_conceal,
  output logic reuse_prev_spectrum,
  output logic overlap_add_combine,
  // status
  output logic phase_align_allowed,
  output logic phase_align_continue,
  output logic stationary_final
);

  stationarity_if st ();

  loss_mode_pkg::conceal_mode_e mode;
  loss_mode_pkg::conceal_mode_e next_mode;
  logic prev_bad;
  logic next_prev_bad;
  logic pa_allowed;
  logic next_pa_allowed;
  logic pa_continue;
  logic next_pa_continue;
  logic [loss_mode_pkg::HIST_W-1:0] transient_hist;
  logic [loss_mode_pkg::HIST_W-1:0] next_transient_hist;
  logic fd_conceal;
  logic next_fd_conceal;
  logic valid;
  logic next_valid;
  logic low_energy;
  logic run_one;
  logic run_many;
  logic phase_clear;
  logic stat_or_low;
  logic peak_in_band;
  logic match_pa_erased;
  logic match_pa_next_good;
  logic match_pa_burst;
  logic match_rs_erased;
  logic match_rs_next_good;
  logic match_after_burst;
  logic eligible_now;

  ////////////////////////////////////////////////////////////////////////
  // stationarity tracker, updated once per frame
  assign st.update = frame_strobe;
  assign st.energy_delta = energy_delta;

  stationarity_tracker u_stat (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .st(st.tracker)
  );

  ////////////////////////////////////////////////////////////////////////
  // decision terms
  assign low_energy = (energy_delta < loss_mode_pkg::ED_THRESH_Q16);
  assign run_one = (lost_frame_run_count == loss_mode_pkg::RUN_ONE);
  assign run_many = (lost_frame_run_count > loss_mode_pkg::RUN_ONE);
  assign phase_clear = !pa_allowed && !pa_continue;
  assign stat_or_low = st.stationary_final || low_energy;
  assign peak_in_band = (peak_band_hz >= loss_mode_pkg::PEAK_LO_HZ) && (peak_band_hz <= loss_mode_pkg::PEAK_HI_HZ);

  ////////////////////////////////////////////////////////////////////////
  // one term per column of the selection table, flags taken from before the strobe
  assign match_pa_erased = bad_frame && run_one && pa_allowed && !pa_continue;
  assign match_pa_next_good = !bad_frame && prev_bad && pa_continue;
  assign match_pa_burst = bad_frame && prev_bad && pa_continue;
  assign match_rs_erased = bad_frame && phase_clear && stat_or_low;
  assign match_rs_next_good = !bad_frame && prev_bad && phase_clear && stat_or_low;
  assign match_after_burst = !bad_frame && prev_bad && run_many && phase_clear && !stat_or_low;

  // a good frame qualifies when its peak is within 75 to 1000 Hz, steady, calm and no transient is near
  assign eligible_now = peak_in_band && band_index_steady && (energy_delta < loss_mode_pkg::SMALL_CHANGE_Q16)
                        && (transient_hist == loss_mode_pkg::RST_HIST) && !frame_transient;

  ////////////////////////////////////////////////////////////////////////
  // decision group: mode, strobe echo and frequency-domain path

  // mode choice, phase alignment first, then repetition, then fallback
  always_comb begin
    next_mode = mode;
    if (frame_strobe) begin
      if (match_pa_erased) begin
        next_mode = loss_mode_pkg::MODE_PA_ERASED;
      end else if (match_pa_next_good) begin
        next_mode = loss_mode_pkg::MODE_PA_NEXT_GOOD;
      end else if (match_pa_burst) begin
        next_mode = loss_mode_pkg::MODE_PA_BURST;
      end else if (match_rs_erased) begin
        next_mode = loss_mode_pkg::MODE_RS_ERASED;
      end else if (match_rs_next_good) begin
        next_mode = loss_mode_pkg::MODE_RS_NEXT_GOOD;
      end else if (match_after_burst) begin
        next_mode = loss_mode_pkg::MODE_NEXT_GOOD_AFTER_BURST;
      end else begin
        next_mode = loss_mode_pkg::MODE_OVERLAP_ADD;
      end
    end
    // strobe echo and frequency-domain path, independent of the time-domain mode
    next_valid = frame_strobe;
    next_fd_conceal = fd_conceal;
    if (frame_strobe) begin
      next_fd_conceal = bad_frame && prev_freq_domain;
    end
  end

  // decision registers, frozen while the clock enable is low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= loss_mode_pkg::MODE_OVERLAP_ADD;
      valid <= loss_mode_pkg::RST_FLAG;
      fd_conceal <= loss_mode_pkg::RST_FLAG;
    end else if (clk_en) begin
      mode <= next_mode;
      valid <= next_valid;
      fd_conceal <= next_fd_conceal;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // continuation group: previous flag and phase alignment carry-over

  // continue is set by a phase-aligned erasure and dropped by any good frame
  always_comb begin
    next_prev_bad = prev_bad;
    next_pa_continue = pa_continue;
    if (frame_strobe) begin
      next_prev_bad = bad_frame;
      if (match_pa_erased || match_pa_burst) begin
        next_pa_continue = 1'b1;
      end else if (!bad_frame) begin
        next_pa_continue = 1'b0;
      end
    end
  end

  // continuation registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_bad <= loss_mode_pkg::RST_FLAG;
      pa_continue <= loss_mode_pkg::RST_FLAG;
    end else if (clk_en) begin
      prev_bad <= next_prev_bad;
      pa_continue <= next_pa_continue;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // eligibility group: memory update on good frames only

  // history and eligibility move only on good frames, bad frames leave them alone
  always_comb begin
    next_pa_allowed = pa_allowed;
    next_transient_hist = transient_hist;
    if (frame_strobe && !bad_frame) begin
      next_pa_allowed = eligible_now;
      next_transient_hist = {transient_hist[loss_mode_pkg::HIST_W-2:0], frame_transient};
    end
  end

  // eligibility registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pa_allowed <= loss_mode_pkg::RST_FLAG;
      transient_hist <= loss_mode_pkg::RST_HIST;
    end else if (clk_en) begin
      pa_allowed <= next_pa_allowed;
      transient_hist <= next_transient_hist;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decision outputs
  assign conceal_mode = mode;
  assign mode_valid = valid;
  assign freq_domain_conceal = fd_conceal;
  assign reuse_prev_spectrum = fd_conceal;
  assign overlap_add_combine = (mode == loss_mode_pkg::MODE_OVERLAP_ADD);

  // status outputs
  assign phase_align_allowed = pa_allowed;
  assign phase_align_continue = pa_continue;
  assign stationary_final = st.stationary_final;

endmodule
`default_nettype wire

//--- testbench/frame_loss_mode_select_chk.sv
// frame_loss_mode_select_chk: port-level checks of the mode selector
// assumes one clock domain, bound into every selector instance
`timescale 1ns/100ps
`default_nettype none
module frame_loss_mode_select_chk (
  // clock and control
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // frame inputs
  input wire logic frame_strobe,
  input wire logic bad_frame,
  input wire logic prev_freq_domain,
  input wire logic [7:0] lost_frame_run_count,
  // decision outputs
  input wire logic [6:0] conceal_mode,
  input wire logic mode_valid,
  input wire logic freq_domain_conceal,
  input wire logic reuse_prev_spectrum,
  input wire logic overlap_add_combine,
  input wire logic phase_align_allowed,
  input wire logic phase_align_continue
);
  logic take;
  // a strobe only counts with the enable high
  assign take = frame_strobe & clk_en;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////
  a_valid_after_take: assert property (take |=> mode_valid) else $error("mode_valid missing");
  a_valid_one_pulse: assert property (mode_valid && clk_en && !take |=> !mode_valid) else $error("long pulse");
  a_mode_held: assert property (!take |=> $stable({conceal_mode, freq_domain_conceal})) else $error("mode moved");
  a_fd_path: assert property (take |=> freq_domain_conceal == $past(bad_frame & prev_freq_domain))
    else $error("fd path wrong");
  a_spectrum_reuse: assert property (reuse_prev_spectrum == freq_domain_conceal) else $error("reuse wrong");
  a_overlap_combine: assert property (overlap_add_combine ==
    (conceal_mode == loss_mode_pkg::MODE_OVERLAP_ADD)) else $error("combine wrong");
  a_mode_onehot: assert property ($onehot(conceal_mode)) else $error("mode not one-hot");
  a_pa_erased: assert property (take && bad_frame && lost_frame_run_count == 8'h01 && phase_align_allowed
    && !phase_align_continue |=> conceal_mode == loss_mode_pkg::MODE_PA_ERASED ##0 phase_align_continue)
    else $error("pa erased missed");
  a_pa_burst: assert property (take && bad_frame && phase_align_continue |=>
    conceal_mode == loss_mode_pkg::MODE_PA_BURST) else $error("pa burst missed");
  a_pa_next_good: assert property (take && !bad_frame && phase_align_continue |=>
    conceal_mode == loss_mode_pkg::MODE_PA_NEXT_GOOD && !phase_align_continue) else $error("pa next missed");
  // main scenarios reached
  c_pa_erased: cover property (conceal_mode == loss_mode_pkg::MODE_PA_ERASED);
  c_rs_next: cover property (conceal_mode == loss_mode_pkg::MODE_RS_NEXT_GOOD);
  c_after_burst: cover property (conceal_mode == loss_mode_pkg::MODE_NEXT_GOOD_AFTER_BURST);
endmodule
bind frame_loss_mode_select frame_loss_mode_select_chk i_chk (.core_clk, .rst_n, .clk_en, .frame_strobe,
  .bad_frame, .prev_freq_domain, .lost_frame_run_count, .conceal_mode, .mode_valid, .freq_domain_conceal,
  .reuse_prev_spectrum, .overlap_add_combine, .phase_align_allowed, .phase_align_continue);
`default_nettype wire

//--- testbench/frame_decoder_model.sv
// frame_decoder_model: frame decoder feeding the selector
// assumes its tasks are called at the falling clock edge
`timescale 1ns/100ps
`default_nettype none
module frame_decoder_model (
  // clock
  input wire logic core_clk,
  // frame fields
  output logic frame_strobe,
  output logic bad_frame,
  output logic prev_freq_domain,
  output logic [7:0] lost_frame_run_count,
  output logic [15:0] energy_delta,
  output logic [15:0] peak_band_hz,
  output logic band_index_steady,
  output logic frame_transient
);
  logic [7:0] run = 8'h00;
  logic last_b = 1'b0;
  initial {frame_strobe, bad_frame, prev_freq_domain, lost_frame_run_count, energy_delta, peak_band_hz,
    band_index_steady, frame_transient} = '0;
  // one frame for one cycle, strobe left high for back-to-back use
  task automatic send(input logic b, fd, input logic [15:0] ed, hz, input logic st, tr);
    run = b ? (last_b ? run + 8'h01 : 8'h01) : (last_b ? run : 8'h00);
    last_b = b;
    {frame_strobe, bad_frame, prev_freq_domain, lost_frame_run_count} = {1'b1, b, fd, run};
    {energy_delta, peak_band_hz, band_index_steady, frame_transient} = {ed, hz, st, tr};
    @(negedge core_clk);
  endtask
  // gap cycle, fields no longer valid so bad_frame, run count and energy_delta are inverted
  task automatic idle();
    frame_strobe = 1'b0;
    {bad_frame, lost_frame_run_count, energy_delta} = ~{bad_frame, lost_frame_run_count, energy_delta};
    @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

//--- testbench/frame_loss_mode_select_bench.sv
// frame_loss_mode_select_bench: corner and random frames against a reference
// assumes the decoder model drives frames, the bench drives clk_en and rst_n
`timescale 1ns/100ps
`default_nettype none
module frame_loss_mode_select_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic frame_strobe, bad_frame, prev_freq_domain, band_index_steady, frame_transient;
  logic [7:0] lost_frame_run_count;
  logic [15:0] energy_delta, peak_band_hz;
  logic [6:0] conceal_mode;
  logic mode_valid, freq_domain_conceal, reuse_prev_spectrum, overlap_add_combine;
  logic phase_align_allowed, phase_align_continue, stationary_final;
  logic pbad = 1'b0, pok = 1'b0, cont = 1'b0, sprev = 1'b0, sfin = 1'b0;
  logic [2:0] hist = 3'h0;
  logic [11:0] last = 12'h001;
  logic [15:0] eds [4] = '{16'h083E, 16'h083F, 16'h28B8, 16'h28B9};
  logic [15:0] hzs [4] = '{16'h004A, 16'h004B, 16'h03E8, 16'h03E9};
  int failures = 0;
  int total_checks = 0;
  wire logic [13:0] seen = {overlap_add_combine, reuse_prev_spectrum, mode_valid, freq_domain_conceal,
    phase_align_allowed, phase_align_continue, stationary_final, conceal_mode};
  always #5 core_clk = ~core_clk;
  frame_decoder_model i_dec (.core_clk, .frame_strobe, .bad_frame, .prev_freq_domain, .lost_frame_run_count,
    .energy_delta, .peak_band_hz, .band_index_steady, .frame_transient);
  frame_loss_mode_select i_dut (.core_clk, .rst_n, .clk_en, .frame_strobe, .bad_frame, .prev_freq_domain,
    .lost_frame_run_count, .energy_delta, .peak_band_hz, .band_index_steady, .frame_transient, .conceal_mode,
    .mode_valid, .freq_domain_conceal, .reuse_prev_spectrum, .overlap_add_combine, .phase_align_allowed,
    .phase_align_continue, .stationary_final);
  //////////////////////////////////////////
  // expected mode from the flags held before this strobe
  function automatic logic [6:0] pick(logic b, logic [7:0] run, logic [15:0] ed);
    logic rs;
    logic off;
    rs = sfin | (ed < loss_mode_pkg::ED_THRESH_Q16);
    off = !pok & !cont;
    if (b & run == 8'h01 & pok & !cont) return loss_mode_pkg::MODE_PA_ERASED;
    if (!b & pbad & cont) return loss_mode_pkg::MODE_PA_NEXT_GOOD;
    if (b & pbad & cont) return loss_mode_pkg::MODE_PA_BURST;
    if (b & off & rs) return loss_mode_pkg::MODE_RS_ERASED;
    if (!b & pbad & off & rs) return loss_mode_pkg::MODE_RS_NEXT_GOOD;
    if (!b & pbad & off & run > 8'h01) return loss_mode_pkg::MODE_NEXT_GOOD_AFTER_BURST;
    return loss_mode_pkg::MODE_OVERLAP_ADD;
  endfunction
  // compare and count
  task automatic check(input logic [13:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask
  // one frame: drive it, advance the reference, compare
  task automatic frame(input logic b, fd, input logic [15:0] ed, hz, input logic st, tr);
    logic [6:0] m;
    logic now;
    logic [13:0] want;
    i_dec.send(b, fd, ed, hz, st, tr);
    m = pick(b, i_dec.run, ed);
    now = ed < loss_mode_pkg::STAT_THRESH_Q16;
    if (clk_en) begin
      if (now == sprev) sfin = now;
      sprev = now;
      if (!b) begin
        pok = hz >= loss_mode_pkg::PEAK_LO_HZ & hz <= loss_mode_pkg::PEAK_HI_HZ & st & hist == 3'h0 & !tr
          & ed < loss_mode_pkg::SMALL_CHANGE_Q16;
        hist = {hist[1:0], tr};
      end
      cont = b & (cont | m == loss_mode_pkg::MODE_PA_ERASED | m == loss_mode_pkg::MODE_PA_BURST);
      pbad = b;
      last = {1'b1, b & fd, pok, cont, sfin, m};
    end
    want = {last[6:0] == loss_mode_pkg::MODE_OVERLAP_ADD, last[10], clk_en & last[11], last[10:0]};
    check(seen, want);
  endtask
  // counts and verdict
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    logic b;
    void'($urandom(32'h7BF524C6));
    repeat (16) @(negedge core_clk);
    check(seen, {1'b1, 6'h00, loss_mode_pkg::MODE_OVERLAP_ADD});
    rst_n = 1'b1;
    repeat (3) frame(1'b0, 1'b0, 16'h0000, 16'h004B, 1'b1, 1'b0);
    repeat (2) frame(1'b1, 1'b1, 16'h0000, 16'h004B, 1'b1, 1'b0);
    frame(1'b0, 1'b0, 16'h0000, 16'h03E8, 1'b1, 1'b0);
    frame(1'b0, 1'b0, 16'h4000, 16'h03E9, 1'b1, 1'b0);
    repeat (3) frame(1'b1, 1'b0, 16'h4000, 16'h03E9, 1'b1, 1'b0);
    frame(1'b0, 1'b0, 16'h4000, 16'h03E9, 1'b1, 1'b0);
    i_dec.idle();
    clk_en = 1'b0;
    frame(1'b1, 1'b1, 16'h0000, 16'h004B, 1'b1, 1'b0);
    clk_en = 1'b1;
    // mid-run reset: everything back to overlap-add, reference state cleared with it
    rst_n = 1'b0;
    i_dec.idle();
    check(seen, {1'b1, 6'h00, loss_mode_pkg::MODE_OVERLAP_ADD});
    {pbad, pok, cont, sprev, sfin, hist, last} = {5'h00, 3'h0, 12'h001};
    rst_n = 1'b1;
    $display("corner frames done");
    repeat (500) begin
      if ($urandom % 4 == 0) i_dec.idle();
      b = $urandom % 3 == 0;
      frame(b, 1'($urandom), $urandom % 2 ? eds[$urandom % 4] : 16'($urandom % 16'h3000),
        $urandom % 2 ? hzs[$urandom % 4] : 16'h0200, $urandom % 4 != 0, $urandom % 8 == 0);
    end
    $display("random frames done");
    tally_and_finish();
  end
  // hang guard
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
